/* shared/ptd_pkg.sv */
// Constants, types and decoders shared by the tone divider files.
// Assumes a 40 MHz system clock and Avalon-MM byte addressing.
//
// Notes on behaviour
// RL1 - The selected source clock is scaled by a prescaler whose ratio comes from a 2-bit field.
// RL2 - The general counter reloads from an 8-bit divider value register that software reads and writes.
// RL3 - Software picks the source clock: the high-frequency clock divided by four or the 32768 Hz oscillator.
// RL4 - The tone output is driven only while the output enable bit is 1 and stops when it is 0.
// RL5 - Writes to the divider value register are ignored while the divider is disabled.
// RL6 - Hardware holds the divider value register at zero while the divider is disabled.
// RL7 - Tone frequency equals prescaler output frequency over two times the divider value plus one.
// RL8 - The tone toggles each time the counter expires and the counter then reloads, giving 50 percent duty.
package ptd_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h2e;
    localparam logic [7:0] IDX_VALUE = 8'h2f;
    localparam logic [7:0] IDX_STATUS = 8'h30;
    localparam int ADDR_W = 10;

    // Control register fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_PRES_LSB = 2;
    localparam int CTRL_W = 4;

    // Status register fields
    localparam int STAT_TONE_BIT = 0;
    localparam int STAT_CNT_LSB = 8;

    // Reset values
    localparam logic [3:0] CTRL_RST = 4'h0;
    localparam logic [7:0] VALUE_RST = 8'h00;

    // Source selection codes and the fixed high-frequency predivider
    localparam logic SRC_HF = 1'b0;
    localparam logic SRC_OSC = 1'b1;
    localparam logic [1:0] HF_DIV_LAST = 2'h3;

    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } ptd_bus_e;

    // Prescaler terminal count: ratios 1, 2, 4, 8
    function automatic logic [2:0] ptd_pres_last(input logic [1:0] sel);
        logic [2:0] last;
        last = 3'h0;
        unique case (sel)
            2'h0: last = 3'h0;
            2'h1: last = 3'h1;
            2'h2: last = 3'h3;
            2'h3: last = 3'h7;
        endcase
        return last;
    endfunction

    // Word address match for a register index
    function automatic logic ptd_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        return addr == {idx, 2'b00};
    endfunction

endpackage

/* hdl/ptd_prescaler.sv */
// Source clock selection and prescaler for the tone divider.
// Assumes hfTick is a one-cycle pulse on clk; osc32kPin is asynchronous.
`timescale 1ns/1ps

module ptd_prescaler
    import ptd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic enable,
    input wire logic srcSel,
    input wire logic [1:0] presSel,
    input wire logic hfTick,
    input wire logic osc32kPin,
    output logic tick
);

    logic [2:0] oscSync_r, oscSync_nxt;
    logic oscLevel_r, oscLevel_nxt;
    logic [1:0] hfCnt_r, hfCnt_nxt;
    logic [2:0] preCnt_r, preCnt_nxt;
    logic tick_r, tick_nxt;
    logic oscRise, hfPulse, srcPulse;

    // Pin settles once second and third stage agree; first stage feeds only the second
    always_comb begin
        oscSync_nxt = {oscSync_r[1:0], osc32kPin};
        oscLevel_nxt = oscLevel_r;
        oscRise = 1'b0;
        if (oscSync_r[2] == oscSync_r[1] && oscSync_r[2] != oscLevel_r) begin
            oscLevel_nxt = oscSync_r[2];
            oscRise = oscSync_r[2];
        end
    end

    // Source pulse: hf divided by four or oscillator rising edge
    always_comb begin
        hfPulse = hfTick && (hfCnt_r == HF_DIV_LAST);
        srcPulse = (srcSel == SRC_OSC) ? oscRise : hfPulse; // RL3
        hfCnt_nxt = hfCnt_r;
        preCnt_nxt = preCnt_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            hfCnt_nxt = 2'h0;
            preCnt_nxt = 3'h0;
        end else begin
            if (hfTick) begin
                hfCnt_nxt = hfCnt_r + 2'h1;
            end
            if (srcPulse) begin
                if (preCnt_r >= ptd_pres_last(presSel)) begin
                    preCnt_nxt = 3'h0; // RL1
                    tick_nxt = 1'b1;
                end else begin
                    preCnt_nxt = preCnt_r + 3'h1;
                end
            end
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oscSync_r <= 3'h0;
            oscLevel_r <= 1'b0;
            hfCnt_r <= 2'h0;
            preCnt_r <= 3'h0;
            tick_r <= 1'b0;
        end else if (ce) begin
            oscSync_r <= oscSync_nxt;
            oscLevel_r <= oscLevel_nxt;
            hfCnt_r <= hfCnt_nxt;
            preCnt_r <= preCnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    pres_terminal_a: assert property ( // RL1
        ce && enable && srcPulse && preCnt_r == ptd_pres_last(presSel) |=> tick_r)
        else $error("prescaler missed its terminal count");

    hf_quarter_a: assert property ( // RL3
        ce && enable && srcSel == SRC_HF && !(hfTick && hfCnt_r == HF_DIV_LAST) |=> !tick_r)
        else $error("hf source ticked without a fourth input pulse");

endmodule

/* hdl/ptd_tone_divider.sv */
// Programmable tone divider: Avalon-MM register slave, counter and tone pin.
// Assumes a 40 MHz clk, a synchronous active-low reset and one Avalon master.
`timescale 1ns/1ps

module ptd_tone_divider
    import ptd_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic hfTick,
    input wire logic osc32kPin,
    output logic toneOut
);

    ptd_bus_e busState_r, busState_nxt;
    logic waitReq_r, waitReq_nxt;
    logic [31:0] readData_r, readData_nxt;
    logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [7:0] value_r, value_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic tone_r, tone_nxt;
    logic enable, srcSel, tick, accept, wrLow;
    logic [1:0] presSel;

    // Control field decode
    assign enable = ctrl_r[CTRL_EN_BIT];
    assign srcSel = ctrl_r[CTRL_SRC_BIT];
    assign presSel = ctrl_r[CTRL_PRES_LSB +: 2];

    // Request completes on the edge where waitrequest is seen low
    assign accept = (avs_read || avs_write) && !waitReq_r;
    assign wrLow = accept && avs_write && avs_byteenable[0];

    // Bus slave: one wait cycle, then answer for exactly one cycle
    always_comb begin
        busState_nxt = busState_r;
        waitReq_nxt = waitReq_r;
        readData_nxt = readData_r;
        unique case (busState_r)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    busState_nxt = BUS_ACK;
                    waitReq_nxt = 1'b0;
                    readData_nxt = 32'h0;
                    if (avs_read) begin
                        if (ptd_hit(avs_address, IDX_CTRL)) begin
                            readData_nxt[CTRL_W-1:0] = ctrl_r;
                        end else if (ptd_hit(avs_address, IDX_VALUE)) begin
                            readData_nxt[7:0] = value_r; // RL2
                        end else if (ptd_hit(avs_address, IDX_STATUS)) begin
                            readData_nxt[STAT_TONE_BIT] = tone_r;
                            readData_nxt[STAT_CNT_LSB +: 8] = cnt_r;
                        end
                    end
                end
            end
            BUS_ACK: begin
                busState_nxt = BUS_IDLE;
                waitReq_nxt = 1'b1;
            end
        endcase
    end

    // Register file writes; value is locked at zero while disabled
    always_comb begin
        ctrl_nxt = ctrl_r;
        value_nxt = value_r;
        if (wrLow && ptd_hit(avs_address, IDX_CTRL)) begin
            ctrl_nxt = avs_writedata[CTRL_W-1:0];
        end
        if (!enable) begin // RL5
            value_nxt = 8'h00; // RL6
        end else if (wrLow && ptd_hit(avs_address, IDX_VALUE)) begin
            value_nxt = avs_writedata[7:0]; // RL2
        end
    end

    // Source and prescaler produce one tick per prescaler output period
    ptd_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .enable(enable),
        .srcSel(srcSel),
        .presSel(presSel),
        .hfTick(hfTick),
        .osc32kPin(osc32kPin),
        .tick(tick)
    );

    // Half period is N+1 ticks; a new value lands at the next reload
    always_comb begin
        cnt_nxt = cnt_r;
        tone_nxt = tone_r;
        if (!enable) begin
            cnt_nxt = 8'h00;
            tone_nxt = 1'b0; // RL4
        end else if (tick) begin
            if (cnt_r == 8'h00) begin
                cnt_nxt = value_r; // RL7
                tone_nxt = !tone_r; // RL8
            end else begin
                cnt_nxt = cnt_r - 8'h01; // RL7
            end
        end
    end

    // All state, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busState_r <= BUS_IDLE;
            waitReq_r <= 1'b1;
            readData_r <= 32'h0;
            ctrl_r <= CTRL_RST;
            value_r <= VALUE_RST;
            cnt_r <= 8'h00;
            tone_r <= 1'b0;
        end else if (ce) begin
            busState_r <= busState_nxt;
            waitReq_r <= waitReq_nxt;
            readData_r <= readData_nxt;
            ctrl_r <= ctrl_nxt;
            value_r <= value_nxt;
            cnt_r <= cnt_nxt;
            tone_r <= tone_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign avs_readdata = readData_r;
    assign avs_waitrequest = waitReq_r;
    assign toneOut = tone_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    value_cleared_a: assert property ( // RL6
        ce && !enable |=> value_r == 8'h00)
        else $error("divider value not cleared while disabled");

    locked_write_a: assert property ( // RL5
        ce && !enable && avs_write && !waitReq_r && ptd_hit(avs_address, IDX_VALUE)
        |=> value_r == 8'h00)
        else $error("divider value written while disabled");

    value_write_a: assert property ( // RL2
        ce && enable && wrLow && ptd_hit(avs_address, IDX_VALUE)
        |=> value_r == 8'($past(avs_writedata)))
        else $error("divider value write lost while enabled");

    tone_off_a: assert property ( // RL4
        ce && !enable |=> !toneOut)
        else $error("tone driven while output disabled");

    expiry_toggle_a: assert property ( // RL8
        ce && enable && tick && cnt_r == 8'h00 |=> toneOut != $past(toneOut))
        else $error("tone did not toggle on expiry");

    expiry_reload_a: assert property ( // RL7
        ce && enable && tick && cnt_r == 8'h00 |=> cnt_r == $past(value_r))
        else $error("counter not reloaded on expiry");

    count_down_a: assert property ( // RL7
        ce && enable && tick && cnt_r != 8'h00 |=> cnt_r == $past(cnt_r) - 8'h01 && $stable(toneOut))
        else $error("counter step or tone wrong between expiries");

    idle_hold_a: assert property ( // RL8
        ce && enable && !tick |=> $stable(toneOut) && $stable(cnt_r))
        else $error("tone or counter moved without a tick");

    // Bus handshake: one wait cycle, then exactly one answer cycle
    wait_answer_a: assert property ( // RL2
        ce && busState_r == BUS_IDLE && (avs_read || avs_write) |=> !waitReq_r)
        else $error("request not answered after one wait cycle");

    wait_single_a: assert property ( // RL2
        ce && !waitReq_r |=> waitReq_r)
        else $error("waitrequest low for more than one cycle");

    // Read data carries the register seen when the request was taken
    read_value_a: assert property ( // RL2
        ce && busState_r == BUS_IDLE && avs_read && ptd_hit(avs_address, IDX_VALUE)
        |=> avs_readdata == {24'h0, $past(value_r)})
        else $error("divider value read back wrong");

    read_ctrl_a: assert property ( // RL1
        ce && busState_r == BUS_IDLE && avs_read && ptd_hit(avs_address, IDX_CTRL)
        |=> avs_readdata == {28'h0, $past(ctrl_r)})
        else $error("control register read back wrong");

    read_status_a: assert property ( // RL8
        ce && busState_r == BUS_IDLE && avs_read && ptd_hit(avs_address, IDX_STATUS)
        |=> avs_readdata == {16'h0, $past(cnt_r), 7'h0, $past(tone_r)})
        else $error("status read does not show tone and counter");

    unmapped_zero_a: assert property ( // RL2
        ce && busState_r == BUS_IDLE && avs_read && !ptd_hit(avs_address, IDX_CTRL)
        && !ptd_hit(avs_address, IDX_VALUE) && !ptd_hit(avs_address, IDX_STATUS)
        |=> avs_readdata == 32'h0)
        else $error("unmapped address read nonzero");

    // Control writes land whole; a write without the low byte lane changes nothing
    ctrl_write_a: assert property ( // RL1
        ce && wrLow && ptd_hit(avs_address, IDX_CTRL)
        |=> ctrl_r == CTRL_W'($past(avs_writedata)))
        else $error("control write lost");

    byte_lane_a: assert property ( // RL2
        ce && enable && avs_write && !waitReq_r && !avs_byteenable[0]
        |=> $stable(value_r) && $stable(ctrl_r))
        else $error("write without low byte lane changed a register");

endmodule

/* testbench/tb_ptd_tone_divider.sv */
// Self-checking bench for the tone divider: register access, tone timing, disable.
// Assumes ptd_pkg is compiled first; the bench is the only bus master.
`timescale 1ns/1ps

module tb_ptd_tone_divider
    import ptd_pkg::*;
;
    logic clk, rst_n, ce, avs_read, avs_write, avs_waitrequest, hfTick, osc32kPin, toneOut;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rdq;
    logic [3:0] avs_byteenable, oscDiv;
    logic [7:0] n;
    logic [1:0] p;
    logic s;
    int fails, samples_checked, hi, lo;

    ptd_tone_divider ptd_tone_divider_inst (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .hfTick(hfTick),
        .osc32kPin(osc32kPin),
        .toneOut(toneOut)
    );

    // 40 MHz system clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Source clocks: hf pulse every 2 cycles, oscillator period 16 so sources differ
    always @(posedge clk) begin
        if (!rst_n) begin
            hfTick <= 1'b0;
            oscDiv <= 4'h0;
            osc32kPin <= 1'b0;
        end else begin
            hfTick <= !hfTick;
            oscDiv <= oscDiv + 4'h1;
            osc32kPin <= oscDiv[3];
        end
    end

    task give_verdict;
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chkReg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t register got %h want %h", $time, got, exp);
        end
    endtask

    task chkLen(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fails++;
            $display("BAD %0t half period got %0d want %0d", $time, got, exp);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low
    task busOp(input logic wr, input logic [7:0] idx, input logic [31:0] d,
               input logic [3:0] be);
        int k;
        @(posedge clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 40);
        if (k >= 40) begin
            fails++;
            give_verdict;
        end
        rdq = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // Cycles until the tone is sampled at level v; bounded
    task waitTone(input logic v, output int len);
        len = 0;
        while (toneOut !== v && len < 20000) begin
            @(posedge clk);
            len++;
        end
        if (len >= 20000) begin
            fails++;
            give_verdict;
        end
    endtask

    // Half period in clk cycles: hf source is 4 pulses of 2 cycles, osc period 16
    function automatic int expHalf(input logic src, input logic [1:0] pr, input logic [7:0] nv);
        return (int'(nv) + 1) * (1 << pr) * (src ? 16 : 8);
    endfunction

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        fails = 0;
        samples_checked = 0;
        void'($urandom(32'h2caad010));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        busOp(1'b0, IDX_CTRL, 32'h0, 4'hf);
        chkReg(rdq, {28'h0, CTRL_RST});
        busOp(1'b1, IDX_VALUE, 32'h5a, 4'hf);
        busOp(1'b0, IDX_VALUE, 32'h0, 4'hf);
        chkReg(rdq, {24'h0, VALUE_RST});
        busOp(1'b0, 8'hff, 32'h0, 4'hf);
        chkReg(rdq, 32'h0);
        // Every source and prescaler code, then the largest divider value
        for (int i = 0; i < 9; i++) begin
            s = i[2];
            p = i[1:0];
            n = (i == 8) ? 8'hff : 8'($urandom_range(7));
            busOp(1'b1, IDX_CTRL, {28'h0, p, s, 1'b1}, 4'hf);
            busOp(1'b1, IDX_VALUE, {24'h0, n}, 4'hf);
            busOp(1'b1, IDX_VALUE, {24'h0, ~n}, 4'he);
            busOp(1'b0, IDX_VALUE, 32'h0, 4'hf);
            chkReg(rdq, {24'h0, n});
            waitTone(1'b0, hi);
            waitTone(1'b1, hi);
            waitTone(1'b0, hi);
            waitTone(1'b1, lo);
            chkLen(hi, expHalf(s, p, n));
            chkLen(lo, expHalf(s, p, n));
        end
        // Tone just rose with a 2048-cycle half period; ce low must hold it past that
        ce <= 1'b0;
        repeat (3000) @(posedge clk);
        chkReg({31'h0, toneOut}, 32'h1);
        ce <= 1'b1;
        busOp(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chkReg({rdq[31:16], 8'h00, rdq[7:0]}, 32'h1);
        // Disable mid-tone: pin, value and status all fall to zero
        busOp(1'b1, IDX_CTRL, 32'h0, 4'hf);
        repeat (3) @(posedge clk);
        chkReg({31'h0, toneOut}, 32'h0);
        busOp(1'b0, IDX_VALUE, 32'h0, 4'hf);
        chkReg(rdq, 32'h0);
        busOp(1'b0, IDX_STATUS, 32'h0, 4'hf);
        chkReg(rdq, 32'h0);
        busOp(1'b1, IDX_VALUE, 32'h33, 4'hf);
        repeat (100) @(posedge clk);
        chkReg({31'h0, toneOut}, 32'h0);
        // Re-enable shows the cleared value, not the refused write
        busOp(1'b1, IDX_CTRL, 32'h1, 4'hf);
        busOp(1'b0, IDX_VALUE, 32'h0, 4'hf);
        chkReg(rdq, 32'h0);
        give_verdict;
    end
endmodule
